// ==== design/adsc_pkg.sv ====
// constants and types of the antenna driver segment control block
// assumes one clock; registers sit behind an AXI4-Lite slave
package adsc_pkg;

	// ==================================================
	// bus shape
	localparam int ADSC_AW = 12;
	localparam int ADSC_DW = 32;
	localparam logic [1:0] ADSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADSC_RESP_SLVERR = 2'h2;

	// ==================================================
	// register indices, byte address is four times these
	localparam logic [9:0] ADSC_IDX_CTRL = 10'h024;
	localparam logic [9:0] ADSC_IDX_RESULT = 10'h025;
	localparam logic [9:0] ADSC_IDX_MODMASK = 10'h026;
	localparam logic [9:0] ADSC_IDX_NORMMASK = 10'h027;
	localparam logic [9:0] ADSC_IDX_CMD = 10'h030;
	localparam logic [9:0] ADSC_IDX_IRQ_STAT = 10'h031;
	localparam logic [9:0] ADSC_IDX_IRQ_MASK = 10'h032;

	// ==================================================
	// values after reset and special values
	localparam logic [7:0] ADSC_REG_RST = 8'h00;
	localparam logic [1:0] ADSC_IRQ_RST = 2'h0;
	localparam logic [7:0] ADSC_CAL_FAIL_VAL = 8'hFF;
	localparam logic [7:0] ADSC_TRISTATE_VAL = 8'hFF;
	localparam logic [7:0] ADSC_CTRL_WMASK = 8'hFE;

	// ==================================================
	// field positions
	localparam int ADSC_SEL_BIT = 7;
	localparam int ADSC_DEPTH_MSB = 6;
	localparam int ADSC_DEPTH_LSB = 1;
	localparam int ADSC_CMD_DEFAULT_BIT = 0;
	localparam int ADSC_CMD_CAL_BIT = 1;
	localparam int ADSC_IRQ_DONE_BIT = 0;
	localparam int ADSC_IRQ_FAIL_BIT = 1;

	// ==================================================
	// types
	typedef struct packed {
		logic done;
		logic fail;
		logic [7:0] mask;
	} adsc_cal_s;

	typedef enum logic [1:0] {
		ADSC_W_IDLE = 2'h1,
		ADSC_W_RESP = 2'h2
	} adsc_wr_e;

	typedef enum logic [1:0] {
		ADSC_R_IDLE = 2'h1,
		ADSC_R_RESP = 2'h2
	} adsc_rd_e;

endpackage

// ==== design/adsc_top.sv ====
// antenna driver segment control registers with AXI4-Lite slave
// assumes calibration engine and transmitter share I_CLK
//
// Summary of operation
// - select 0: depth field sets modulated level
// - select 0: calibration adjusts modulated level
// - select 1: software mask sets modulated level
// - modulated mask ones disable segments, select 1
// - eight binary-weighted segments, one bit each
// - result register shows calibrated segment mask
// - failed calibration loads result with all ones
// - normal mask ones disable segments normally
// - bit 7 strongest segment, bit 0 weakest
// - normal mask all ones tristates drivers
// - result cleared at reset and set-default
// - control and masks cleared likewise
//
// Chosen here: register access over AXI4-Lite.
module adsc_top (
	input wire logic I_CLK, // 250 MHz
	input wire logic I_RESET_N, // async reset
	input wire logic I_CE, // freezes state when low
	input wire logic I_AWVALID, // write address valid
	output logic O_AWREADY, // write address ready
	input wire logic [adsc_pkg::ADSC_AW-1:0] I_AWADDR, // byte addr
	input wire logic I_WVALID, // write data valid
	output logic O_WREADY, // write data ready
	input wire logic [adsc_pkg::ADSC_DW-1:0] I_WDATA, // write data
	input wire logic [3:0] I_WSTRB, // byte enables
	output logic O_BVALID, // write response valid
	input wire logic I_BREADY, // write response ready
	output logic [1:0] O_BRESP, // write response
	input wire logic I_ARVALID, // read address valid
	output logic O_ARREADY, // read address ready
	input wire logic [adsc_pkg::ADSC_AW-1:0] I_ARADDR, // byte addr
	output logic O_RVALID, // read data valid
	input wire logic I_RREADY, // read data ready
	output logic [adsc_pkg::ADSC_DW-1:0] O_RDATA, // read data
	output logic [1:0] O_RRESP, // read response
	input wire logic I_AM_STATE, // transmitter in modulated state
	input wire adsc_pkg::adsc_cal_s I_CAL, // calibration outcome
	output logic O_CAL_START, // calibration command pulse
	output logic [5:0] O_CAL_DEPTH, // depth target
	output logic [7:0] O_MOD_MASK, // modulated level in force
	output logic [7:0] O_SEG_OFF, // segments disabled now
	output logic O_DRV_TRISTATE, // drivers tristated
	output logic O_IRQ // interrupt, level
);
	import adsc_pkg::*;

	// ==================================================
	// declarations
	logic [7:0] ctrl;
	logic [7:0] result;
	logic [7:0] mod_mask;
	logic [7:0] norm_mask;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic set_default;
	logic cal_busy;
	adsc_wr_e wr_state;
	adsc_rd_e rd_state;
	logic aw_held;
	logic w_held;
	logic [9:0] aw_idx;
	logic [7:0] wdata;
	logic wstrb0;
	logic wr_fire;
	logic wr_lane;
	logic [9:0] ar_idx;
	logic [31:0] next_rdata;
	logic next_rerr;
	logic [7:0] mod_level;

	// ==================================================
	// bus handshakes
	// one write at a time: address and data are taken in any order
	// handshakes close while frozen, so no beat is lost or repeated
	assign O_AWREADY = I_CE && !aw_held && (wr_state == ADSC_W_IDLE);
	assign O_WREADY = I_CE && !w_held && (wr_state == ADSC_W_IDLE);
	assign O_BVALID = I_CE && (wr_state == ADSC_W_RESP);
	assign O_ARREADY = I_CE && (rd_state == ADSC_R_IDLE);
	assign O_RVALID = I_CE && (rd_state == ADSC_R_RESP);
	assign wr_fire = (wr_state == ADSC_W_IDLE) && aw_held && w_held;
	// registers hold data in the low byte lane only
	assign wr_lane = wr_fire && wstrb0;
	assign ar_idx = I_ARADDR[11:2];

	// write address capture
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			aw_held <= 1'b0;
			aw_idx <= 10'h000;
		end else if (I_CE) begin
			if (I_AWVALID && O_AWREADY) begin
				aw_held <= 1'b1;
				aw_idx <= I_AWADDR[11:2];
			end else if (O_BVALID && I_BREADY) begin
				aw_held <= 1'b0;
			end
		end
	end

	// write data capture
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			w_held <= 1'b0;
			wdata <= 8'h00;
			wstrb0 <= 1'b0;
		end else if (I_CE) begin
			if (I_WVALID && O_WREADY) begin
				w_held <= 1'b1;
				wdata <= I_WDATA[7:0];
				wstrb0 <= I_WSTRB[0];
			end else if (O_BVALID && I_BREADY) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response: unmapped addresses answer slverr
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wr_state <= ADSC_W_IDLE;
			O_BRESP <= ADSC_RESP_OKAY;
		end else if (I_CE) begin
			case (wr_state)
				ADSC_W_IDLE: begin
					if (wr_fire) begin
						wr_state <= ADSC_W_RESP;
						O_BRESP <= is_mapped(aw_idx) ?
							ADSC_RESP_OKAY : ADSC_RESP_SLVERR;
					end
				end
				ADSC_W_RESP: begin
					if (I_BREADY) begin
						wr_state <= ADSC_W_IDLE;
					end
				end
				default: begin
					wr_state <= ADSC_W_IDLE;
				end
			endcase
		end
	end

	// address map check
	function automatic logic is_mapped(input logic [9:0] idx);
		is_mapped = (idx == ADSC_IDX_CTRL) || (idx == ADSC_IDX_RESULT) ||
			(idx == ADSC_IDX_MODMASK) || (idx == ADSC_IDX_NORMMASK) ||
			(idx == ADSC_IDX_CMD) || (idx == ADSC_IDX_IRQ_STAT) ||
			(idx == ADSC_IDX_IRQ_MASK);
	endfunction

	// read mux, upper bits read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr = 1'b0;
		case (ar_idx)
			ADSC_IDX_CTRL: next_rdata[7:0] = ctrl;
			ADSC_IDX_RESULT: next_rdata[7:0] = result;
			ADSC_IDX_MODMASK: next_rdata[7:0] = mod_mask;
			ADSC_IDX_NORMMASK: next_rdata[7:0] = norm_mask;
			ADSC_IDX_CMD: next_rdata[ADSC_CMD_CAL_BIT] = cal_busy;
			ADSC_IDX_IRQ_STAT: next_rdata[1:0] = irq_stat;
			ADSC_IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
			default: next_rerr = 1'b1;
		endcase
	end

	// read channel: data registered one cycle after address
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rd_state <= ADSC_R_IDLE;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= ADSC_RESP_OKAY;
		end else if (I_CE) begin
			case (rd_state)
				ADSC_R_IDLE: begin
					if (I_ARVALID) begin
						rd_state <= ADSC_R_RESP;
						O_RDATA <= next_rdata;
						O_RRESP <= next_rerr ?
							ADSC_RESP_SLVERR : ADSC_RESP_OKAY;
					end
				end
				ADSC_R_RESP: begin
					if (I_RREADY) begin
						rd_state <= ADSC_R_IDLE;
					end
				end
				default: begin
					rd_state <= ADSC_R_IDLE;
				end
			endcase
		end
	end

	// ==================================================
	// commands
	// set-default and calibrate are one-cycle pulses from a write
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			set_default <= 1'b0;
			O_CAL_START <= 1'b0;
		end else if (I_CE) begin
			set_default <= wr_lane && (aw_idx == ADSC_IDX_CMD) &&
				wdata[ADSC_CMD_DEFAULT_BIT];
			O_CAL_START <= wr_lane && (aw_idx == ADSC_IDX_CMD) &&
				wdata[ADSC_CMD_CAL_BIT];
		end
	end

	// busy from start until the engine reports done
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cal_busy <= 1'b0;
		end else if (I_CE) begin
			if (O_CAL_START) begin
				cal_busy <= 1'b1;
			end else if (I_CAL.done) begin
				cal_busy <= 1'b0;
			end
		end
	end

	// ==================================================
	// configuration registers
	// defaults on reset and set-default
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl <= ADSC_REG_RST;
			mod_mask <= ADSC_REG_RST;
			norm_mask <= ADSC_REG_RST;
		end else if (I_CE) begin
			if (set_default) begin
				ctrl <= ADSC_REG_RST;
				mod_mask <= ADSC_REG_RST;
				norm_mask <= ADSC_REG_RST;
			end else if (wr_lane) begin
				if (aw_idx == ADSC_IDX_CTRL) begin
					ctrl <= wdata & ADSC_CTRL_WMASK;
				end
				if (aw_idx == ADSC_IDX_MODMASK) begin
					mod_mask <= wdata;
				end
				if (aw_idx == ADSC_IDX_NORMMASK) begin
					norm_mask <= wdata;
				end
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			result <= ADSC_REG_RST;
		end else if (I_CE) begin
			if (set_default) begin
				result <= ADSC_REG_RST;
			end else if (I_CAL.done) begin
				result <= I_CAL.fail ? ADSC_CAL_FAIL_VAL : I_CAL.mask;
			end
		end
	end

	// ==================================================
	// driver outputs
	// depth field is the calibration target
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_CAL_DEPTH <= 6'h00;
		end else if (I_CE) begin
			O_CAL_DEPTH <= ctrl[ADSC_DEPTH_MSB:ADSC_DEPTH_LSB];
		end
	end

	assign mod_level = ctrl[ADSC_SEL_BIT] ? mod_mask : result;

	// one bit per segment, bit 7 the 2 ohm one
	// weight order kept bit for bit
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_MOD_MASK <= ADSC_REG_RST;
			O_SEG_OFF <= ADSC_REG_RST;
		end else if (I_CE) begin
			O_MOD_MASK <= mod_level;
			O_SEG_OFF <= I_AM_STATE ? mod_level : norm_mask;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_DRV_TRISTATE <= 1'b0;
		end else if (I_CE) begin
			O_DRV_TRISTATE <= (norm_mask == ADSC_TRISTATE_VAL);
		end
	end

	// ==================================================
	// interrupts
	// a set in the clearing cycle survives the clear
	assign irq_set = {I_CAL.done && I_CAL.fail, I_CAL.done};
	assign irq_clr = (wr_lane && aw_idx == ADSC_IDX_IRQ_STAT) ?
		wdata[1:0] : 2'h0;

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			irq_stat <= ADSC_IRQ_RST;
			irq_mask <= ADSC_IRQ_RST;
			O_IRQ <= 1'b0;
		end else if (I_CE) begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			if (wr_lane && aw_idx == ADSC_IDX_IRQ_MASK) begin
				irq_mask <= wdata[1:0];
			end
			O_IRQ <= |(irq_stat & irq_mask);
		end
	end

	// ==================================================
	// assertions
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESET_N);

	mod_level_src_a: assert property (
		I_CE |=> O_MOD_MASK == ($past(ctrl[7]) ? $past(mod_mask) :
			$past(result)))
		else $error("modulated level from wrong source");

	cal_adjust_a: assert property (
		I_CE && !set_default && I_CAL.done && !I_CAL.fail ##1
		I_CE && !ctrl[ADSC_SEL_BIT] |=>
		O_MOD_MASK == $past(I_CAL.mask, 2))
		else $error("calibration did not reach level");

	cal_fail_load_a: assert property (
		I_CE && !set_default && I_CAL.done && I_CAL.fail
		|=> result == 8'hFF)
		else $error("failed calibration not all ones");

	depth_target_a: assert property (
		I_CE |=> O_CAL_DEPTH == $past(ctrl[6:1]))
		else $error("depth target not from field");

	mod_seg_off_a: assert property (
		I_CE && I_AM_STATE |=> O_SEG_OFF == $past(mod_level))
		else $error("modulated segments wrong");

	norm_seg_off_a: assert property (
		I_CE && !I_AM_STATE |=> O_SEG_OFF == $past(norm_mask))
		else $error("normal segments wrong");

	tristate_a: assert property (
		I_CE |=> O_DRV_TRISTATE == ($past(norm_mask) == 8'hFF))
		else $error("tristate flag does not follow mask");

	result_clear_a: assert property (
		I_CE && set_default |=> result == 8'h00)
		else $error("result not cleared");

	regs_default_a: assert property (
		I_CE && set_default |=> ctrl == 8'h00 && mod_mask == 8'h00 &&
			norm_mask == 8'h00)
		else $error("registers not defaulted");

	ctrl_bit0_a: assert property (
		ctrl[0] == 1'b0)
		else $error("control bit 0 set");

	freeze_a: assert property (
		!I_CE |=> $stable(result) && $stable(O_SEG_OFF))
		else $error("state moved while frozen");

endmodule

// ==== bench/adsc_tb.sv ====
// self-checking bench for the antenna driver segment control block
// assumes the block alone, driven on its AXI4-Lite slave and its pins
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import adsc_pkg::*;

	// ==================================================
	// stimulus and observed signals
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h1;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic am_state = 1'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	adsc_cal_s cal = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic cal_start, drv_tri, irq;
	logic [1:0] bresp, rresp, last_bresp;
	logic [31:0] rdata;
	logic [5:0] depth;
	logic [7:0] mod_mask, seg_off, m, n;
	logic [33:0] exp_q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int cal_starts = 0;

	// free-running bench clock, 4 ns period
	always #2 clk = ~clk;

	adsc_top u_dut (
		.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
		.I_WSTRB(wstrb), .O_BVALID(bvalid), .I_BREADY(bready),
		.O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_RDATA(rdata), .O_RRESP(rresp), .I_AM_STATE(am_state),
		.I_CAL(cal), .O_CAL_START(cal_start), .O_CAL_DEPTH(depth),
		.O_MOD_MASK(mod_mask), .O_SEG_OFF(seg_off),
		.O_DRV_TRISTATE(drv_tri), .O_IRQ(irq)
	);

	// ==================================================
	// comparison and verdict
	task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==================================================
	// bus master; ready is read at the falling edge, settled
	function automatic logic [11:0] ba(input logic [9:0] i);
		return {i, 2'h0};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ad, wd, ra, rw, b;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge clk);
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(negedge clk);
			ra = awready;
			rw = wready;
			@(posedge clk);
			if (ra && !ad) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (rw && !wd) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do begin
			@(negedge clk);
			b = bvalid;
			last_bresp = bresp;
			@(posedge clk);
		end while (!b);
		bready <= 1'h0;
	endtask

	// expectation is queued before the request goes out
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input logic [1:0] r);
		logic g;
		exp_q.push_back({r, 24'h0, e});
		@(posedge clk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		do begin
			@(negedge clk);
			g = arready;
			@(posedge clk);
		end while (!g);
		arvalid <= 1'h0;
		do begin
			@(negedge clk);
			g = rvalid;
			@(posedge clk);
		end while (!g);
		rready <= 1'h0;
	endtask

	// one-cycle outcome from the calibration engine
	task automatic calib(input logic f, input logic [7:0] k);
		@(posedge clk);
		cal <= '{done: 1'h1, fail: f, mask: k};
		@(posedge clk);
		cal <= '0;
		repeat (3) @(negedge clk);
	endtask

	// read data watcher: a handshake follows every falling edge seen here
	always @(negedge clk) begin
		if (rvalid === 1'h1 && rready === 1'h1) begin
			chk_rd({rresp, rdata}, exp_q.pop_front());
		end
		if (cal_start === 1'h1) begin
			cal_starts++;
		end
	end

	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end

	// ==================================================
	// main sequence
	initial begin
		void'($urandom(32'h1C12));
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			rd(ba(ADSC_IDX_CTRL + 10'(i)), ADSC_REG_RST, ADSC_RESP_OKAY);
		end
		// depth field; bit 0 written high must read back low
		n = (8'($urandom()) & 8'h7F) | 8'h01;
		wr(ba(ADSC_IDX_CTRL), {24'h0, n});
		rd(ba(ADSC_IDX_CTRL), n & ADSC_CTRL_WMASK, ADSC_RESP_OKAY);
		chk_pin({2'h0, depth}, {2'h0, n[6:1]});
		wr(ba(ADSC_IDX_CMD), 32'h2);
		repeat (3) @(negedge clk);
		chk_pin(8'(cal_starts), 8'h01);
		rd(ba(ADSC_IDX_CMD), 8'h02, ADSC_RESP_OKAY);
		// calibration result rules the modulated level with select 0
		m = 8'($urandom());
		calib(1'h0, m);
		rd(ba(ADSC_IDX_RESULT), m, ADSC_RESP_OKAY);
		rd(ba(ADSC_IDX_CMD), 8'h00, ADSC_RESP_OKAY);
		chk_pin(mod_mask, m);
		@(posedge clk);
		am_state <= 1'h1;
		repeat (3) @(negedge clk);
		chk_pin(seg_off, m);
		calib(1'h1, m);
		rd(ba(ADSC_IDX_RESULT), ADSC_CAL_FAIL_VAL, ADSC_RESP_OKAY);
		chk_pin(seg_off, ADSC_CAL_FAIL_VAL);
		// software mask with select 1, then back to select 0
		n = 8'($urandom());
		wr(ba(ADSC_IDX_MODMASK), {24'h0, n});
		wr(ba(ADSC_IDX_CTRL), 32'h80);
		calib(1'h0, m);
		chk_pin(mod_mask, n);
		chk_pin(seg_off, n);
		wr(ba(ADSC_IDX_CTRL), 32'h0);
		repeat (3) @(negedge clk);
		chk_pin(mod_mask, m);
		// walking one through the normal-level mask
		@(posedge clk);
		am_state <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			wr(ba(ADSC_IDX_NORMMASK), 32'h1 << i);
			repeat (3) @(negedge clk);
			chk_pin(seg_off, 8'h01 << i);
			chk_pin({7'h0, drv_tri}, 8'h00);
		end
		wr(ba(ADSC_IDX_NORMMASK), {24'h0, ADSC_TRISTATE_VAL});
		repeat (3) @(negedge clk);
		chk_pin({7'h0, drv_tri}, 8'h01);
		// lane 0 disabled: write ignored; unmapped place refused
		@(posedge clk);
		wstrb <= 4'hE;
		wr(ba(ADSC_IDX_NORMMASK), 32'h0);
		wstrb <= 4'hF;
		rd(ba(ADSC_IDX_NORMMASK), ADSC_TRISTATE_VAL, ADSC_RESP_OKAY);
		rd(12'h0A0, 8'h00, ADSC_RESP_SLVERR);
		wr(12'h0A0, 32'hFF);
		chk_pin({6'h0, last_bresp}, {6'h0, ADSC_RESP_SLVERR});
		// interrupt raised, cleared, then masked
		wr(ba(ADSC_IDX_IRQ_STAT), 32'h3);
		wr(ba(ADSC_IDX_IRQ_MASK), 32'h1);
		calib(1'h0, m);
		chk_pin({7'h0, irq}, 8'h01);
		rd(ba(ADSC_IDX_IRQ_STAT), 8'h01, ADSC_RESP_OKAY);
		wr(ba(ADSC_IDX_IRQ_STAT), 32'h1);
		repeat (3) @(negedge clk);
		chk_pin({7'h0, irq}, 8'h00);
		wr(ba(ADSC_IDX_IRQ_MASK), 32'h0);
		calib(1'h0, m);
		chk_pin({7'h0, irq}, 8'h00);
		// set-default clears the four registers
		wr(ba(ADSC_IDX_CMD), 32'h1);
		repeat (3) @(negedge clk);
		for (int i = 0; i < 4; i++) begin
			rd(ba(ADSC_IDX_CTRL + 10'(i)), ADSC_REG_RST, ADSC_RESP_OKAY);
		end
		chk_pin(mod_mask, ADSC_REG_RST);
		chk_pin({7'h0, drv_tri}, 8'h00);
		// frozen clock enable: a failed outcome must not land
		@(posedge clk);
		ce <= 1'h0;
		calib(1'h1, m);
		@(posedge clk);
		ce <= 1'h1;
		rd(ba(ADSC_IDX_RESULT), ADSC_REG_RST, ADSC_RESP_OKAY);
		rd(ba(ADSC_IDX_IRQ_STAT), 8'h01, ADSC_RESP_OKAY);
		conclude();
	end
endmodule
